/* File: rtcw_pkg.sv */
// rtcw_pkg: constants, register map and types for the calendar clock with wakeup
// assumes a 100 MHz system clock and a 32-bit plain register port
package rtcw_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned TB_HZ = 32_768;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam logic [26:0] TB_STEP = 27'h0008000;
	localparam logic [26:0] TB_WRAP = 27'h5F5E100;
	localparam logic [7:0] PRE_WRAP = 8'h80;
	localparam logic [20:0] CAL_WINDOW = 21'h100000;
	localparam logic signed [10:0] CAL_MIN = -11'sd511;
	localparam logic signed [10:0] CAL_MAX = 11'sd512;
	localparam logic [7:0] SUBSEC_TOP = 8'hFF;
	localparam logic [15:0] STARTUP_SAT = 16'hFFFF;
	// register byte addresses
	localparam logic [7:0] A_DATE = 8'h00;
	localparam logic [7:0] A_TIME = 8'h04;
	localparam logic [7:0] A_SUBSEC = 8'h08;
	localparam logic [7:0] A_WAKE = 8'h0C;
	localparam logic [7:0] A_CAL = 8'h10;
	localparam logic [7:0] A_INFO = 8'h14;
	localparam logic [7:0] A_STATUS = 8'h18;
	localparam logic [7:0] A_MASK = 8'h1C;
	// field positions
	localparam int YEAR_LSB = 16;
	localparam int MONTH_LSB = 8;
	localparam int DAY_LSB = 0;
	localparam int WDAY_LSB = 24;
	localparam int HOUR_LSB = 16;
	localparam int MIN_LSB = 8;
	localparam int SEC_LSB = 0;
	localparam int INFO_POR_BIT = 16;
	localparam int INFO_EXT_BIT = 17;
	localparam int ST_WAKE_BIT = 0;
	localparam int ST_SEC_BIT = 1;
	localparam int ST_W = 2;
	// reset values
	localparam logic [11:0] RST_YEAR = 12'h7D0;
	localparam logic [3:0] RST_MONTH = 4'h1;
	localparam logic [4:0] RST_DAY = 5'h01;
	localparam logic [2:0] RST_WDAY = 3'h6;
	localparam logic [15:0] RST_WAKE = 16'h0000;
	localparam logic signed [10:0] RST_CAL = 11'sd0;
	localparam logic [ST_W-1:0] RST_MASK = 2'h0;

	typedef struct packed {
		logic [11:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [2:0] wday;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} rtcw_cal_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} rtcw_bus_t;
endpackage

/* File: rtcw_top.sv */
// rtcw_top: calendar real-time clock, smooth calibration, millisecond wakeup timer,
// startup and reset-source information, interrupt status and mask.
// assumes: reset-source and oscillator-ready levels arrive asynchronously; the
// register master never strobes read and write together.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module rtcw_top #(
	parameter int unsigned MS_CYCLES = rtcw_pkg::MS_CYCLES,
	parameter logic [26:0] TB_STEP = rtcw_pkg::TB_STEP
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic por_flag,
	input wire logic ext_rst_flag,
	input wire logic osc_ready,
	output logic irq,
	output logic wake_pulse
);
	rtcw_pkg::rtcw_bus_t bus;
	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers: three stages, accept when last two agree
	logic [2:0] s1_r, s2_r, s3_r, filt_r;
	logic [2:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt;
	always_comb
	begin
		s1_nxt = {osc_ready, ext_rst_flag, por_flag};
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		filt_nxt = filt_r;
		for (int i = 0; i < 3; i++)
		begin
			if (s2_r[i] == s3_r[i])
				filt_nxt[i] = s3_r[i];
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			s3_r <= 3'h0;
			filt_r <= 3'h0;
		end
		else
		begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			filt_r <= filt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// millisecond tick, startup measurement, reset-source capture
	logic [31:0] ms_cnt_r, ms_cnt_nxt;
	logic ms_tick_r, ms_tick_nxt;
	logic [15:0] startup_r, startup_nxt;
	logic running_r, running_nxt;
	logic por_seen_r, por_seen_nxt, ext_seen_r, ext_seen_nxt;
	always_comb
	begin
		ms_tick_nxt = (ms_cnt_r == MS_CYCLES - 1);
		ms_cnt_nxt = ms_tick_nxt ? 32'h00000000 : ms_cnt_r + 32'h00000001;
		running_nxt = running_r | filt_r[2];
		startup_nxt = startup_r;
		if (!running_r && ms_tick_r && startup_r != rtcw_pkg::STARTUP_SAT)
			startup_nxt = startup_r + 16'h0001;
		por_seen_nxt = por_seen_r | filt_r[0];
		ext_seen_nxt = ext_seen_r | filt_r[1];
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ms_cnt_r <= 32'h00000000;
			ms_tick_r <= 1'b0;
			startup_r <= 16'h0000;
			running_r <= 1'b0;
			por_seen_r <= 1'b0;
			ext_seen_r <= 1'b0;
		end
		else
		begin
			ms_cnt_r <= ms_cnt_nxt;
			ms_tick_r <= ms_tick_nxt;
			startup_r <= startup_nxt;
			running_r <= running_nxt;
			por_seen_r <= por_seen_nxt;
			ext_seen_r <= ext_seen_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// 32768 Hz timebase and smooth calibration
	// exact fractional divider: no long-term drift from the 100 MHz ratio
	logic [26:0] tb_acc_r, tb_acc_nxt;
	logic [20:0] cal_acc_r, cal_acc_nxt;
	logic [7:0] pre_r, pre_nxt;
	logic step_r, step_nxt;
	logic signed [10:0] cal_r, cal_nxt;
	logic [27:0] tb_sum;
	logic [20:0] cal_sum;
	logic [10:0] cal_mag;
	logic [7:0] pre_sum;
	always_comb
	begin
		// a step equal to the wrap gives one tick per clock: only for short runs
		tb_sum = {1'b0, tb_acc_r} + {1'b0, TB_STEP};
		cal_mag = cal_r[10] ? 11'(-cal_r) : 11'(cal_r);
		cal_sum = cal_acc_r + {10'h000, cal_mag};
		tb_acc_nxt = tb_acc_r;
		cal_acc_nxt = cal_acc_r;
		pre_nxt = pre_r;
		pre_sum = pre_r;
		step_nxt = 1'b0;
		if (running_r)
		begin
			if (tb_sum >= {1'b0, rtcw_pkg::TB_WRAP})
			begin
				tb_acc_nxt = 27'(tb_sum - {1'b0, rtcw_pkg::TB_WRAP});
				// spread |cal| extra or missing ticks evenly over 2^20 ticks
				if (cal_sum >= rtcw_pkg::CAL_WINDOW)
				begin
					cal_acc_nxt = cal_sum - rtcw_pkg::CAL_WINDOW;
					pre_sum = cal_r[10] ? pre_r : pre_r + 8'h02;
				end
				else
				begin
					cal_acc_nxt = cal_sum;
					pre_sum = pre_r + 8'h01;
				end
				if (pre_sum >= rtcw_pkg::PRE_WRAP)
				begin
					pre_nxt = pre_sum - rtcw_pkg::PRE_WRAP;
					step_nxt = 1'b1;
				end
				else
					pre_nxt = pre_sum;
			end
			else
				tb_acc_nxt = tb_sum[26:0];
		end
		cal_nxt = cal_r;
		if (bus.wr && bus.addr == rtcw_pkg::A_CAL)
		begin
			if ($signed(bus.wdata) < $signed(32'(rtcw_pkg::CAL_MIN)))
				cal_nxt = rtcw_pkg::CAL_MIN;
			else if ($signed(bus.wdata) > $signed(32'(rtcw_pkg::CAL_MAX)))
				cal_nxt = rtcw_pkg::CAL_MAX;
			else
				cal_nxt = bus.wdata[10:0];
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tb_acc_r <= 27'h0000000;
			cal_acc_r <= 21'h000000;
			pre_r <= 8'h00;
			step_r <= 1'b0;
			cal_r <= rtcw_pkg::RST_CAL;
		end
		else
		begin
			tb_acc_r <= tb_acc_nxt;
			cal_acc_r <= cal_acc_nxt;
			pre_r <= pre_nxt;
			step_r <= step_nxt;
			cal_r <= cal_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// calendar
	rtcw_pkg::rtcw_cal_t cal_t_r, cal_t_nxt;
	logic [7:0] subsec_r, subsec_nxt;
	logic sec_evt;
	logic [4:0] mdays;
	logic leap;
	always_comb
	begin
		leap = (cal_t_r.year[1:0] == 2'h0) && ((cal_t_r.year % 12'd100 != 12'd0) || (cal_t_r.year % 12'd400 == 12'd0));
		unique case (cal_t_r.month)
			4'h2: mdays = leap ? 5'd29 : 5'd28;
			4'h4, 4'h6, 4'h9, 4'hB: mdays = 5'd30;
			default: mdays = 5'd31;
		endcase
		cal_t_nxt = cal_t_r;
		subsec_nxt = subsec_r;
		sec_evt = 1'b0;
		if (step_r)
		begin
			if (subsec_r == 8'h00)
			begin
				subsec_nxt = rtcw_pkg::SUBSEC_TOP;
				sec_evt = 1'b1;
				cal_t_nxt.sec = cal_t_r.sec + 6'd1;
				if (cal_t_r.sec == 6'd59)
				begin
					cal_t_nxt.sec = 6'd0;
					cal_t_nxt.min = cal_t_r.min + 6'd1;
					if (cal_t_r.min == 6'd59)
					begin
						cal_t_nxt.min = 6'd0;
						cal_t_nxt.hour = cal_t_r.hour + 5'd1;
						if (cal_t_r.hour == 5'd23)
						begin
							cal_t_nxt.hour = 5'd0;
							cal_t_nxt.wday = (cal_t_r.wday >= 3'd7) ? 3'd1 : cal_t_r.wday + 3'd1;
							cal_t_nxt.day = cal_t_r.day + 5'd1;
							if (cal_t_r.day >= mdays)
							begin
								cal_t_nxt.day = 5'd1;
								cal_t_nxt.month = cal_t_r.month + 4'd1;
								if (cal_t_r.month >= 4'd12)
								begin
									cal_t_nxt.month = 4'd1;
									cal_t_nxt.year = cal_t_r.year + 12'd1;
								end
							end
						end
					end
				end
			end
			else
				subsec_nxt = subsec_r - 8'h01;
		end
		// a write overrides the fields it loads in a same-cycle advance; fields it does not load still advance
		if (bus.wr && bus.addr == rtcw_pkg::A_DATE)
		begin
			cal_t_nxt.year = bus.wdata[rtcw_pkg::YEAR_LSB +: 12];
			cal_t_nxt.month = bus.wdata[rtcw_pkg::MONTH_LSB +: 4];
			cal_t_nxt.day = bus.wdata[rtcw_pkg::DAY_LSB +: 5];
			subsec_nxt = rtcw_pkg::SUBSEC_TOP;
		end
		if (bus.wr && bus.addr == rtcw_pkg::A_TIME)
		begin
			cal_t_nxt.wday = bus.wdata[rtcw_pkg::WDAY_LSB +: 3];
			cal_t_nxt.hour = bus.wdata[rtcw_pkg::HOUR_LSB +: 5];
			cal_t_nxt.min = bus.wdata[rtcw_pkg::MIN_LSB +: 6];
			cal_t_nxt.sec = bus.wdata[rtcw_pkg::SEC_LSB +: 6];
			subsec_nxt = rtcw_pkg::SUBSEC_TOP;
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cal_t_r <= '{year: rtcw_pkg::RST_YEAR, month: rtcw_pkg::RST_MONTH, day: rtcw_pkg::RST_DAY,
				wday: rtcw_pkg::RST_WDAY, hour: 5'd0, min: 6'd0, sec: 6'd0};
			subsec_r <= rtcw_pkg::SUBSEC_TOP;
		end
		else
		begin
			cal_t_r <= cal_t_nxt;
			subsec_r <= subsec_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// wakeup timer
	logic [15:0] wake_to_r, wake_to_nxt, wake_cnt_r, wake_cnt_nxt;
	logic wake_pulse_nxt;
	always_comb
	begin
		wake_to_nxt = wake_to_r;
		wake_cnt_nxt = wake_cnt_r;
		wake_pulse_nxt = 1'b0;
		if (wake_to_r == 16'h0000)
			wake_cnt_nxt = 16'h0000;
		else if (ms_tick_r)
		begin
			if (wake_cnt_r + 16'h0001 >= wake_to_r)
			begin
				wake_cnt_nxt = 16'h0000;
				wake_pulse_nxt = 1'b1;
			end
			else
				wake_cnt_nxt = wake_cnt_r + 16'h0001;
		end
		// reprogramming restarts the interval
		if (bus.wr && bus.addr == rtcw_pkg::A_WAKE)
		begin
			wake_to_nxt = bus.wdata[15:0];
			wake_cnt_nxt = 16'h0000;
			wake_pulse_nxt = 1'b0;
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wake_to_r <= rtcw_pkg::RST_WAKE;
			wake_cnt_r <= 16'h0000;
			wake_pulse <= 1'b0;
		end
		else
		begin
			wake_to_r <= wake_to_nxt;
			wake_cnt_r <= wake_cnt_nxt;
			wake_pulse <= wake_pulse_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status, mask, interrupt and read port
	logic [rtcw_pkg::ST_W-1:0] status_r, status_nxt, mask_r, mask_nxt, evt;
	logic irq_nxt;
	logic [31:0] rdata_nxt;
	always_comb
	begin
		evt = '0;
		evt[rtcw_pkg::ST_WAKE_BIT] = wake_pulse;
		evt[rtcw_pkg::ST_SEC_BIT] = sec_evt;
		status_nxt = status_r;
		mask_nxt = mask_r;
		if (bus.wr && bus.addr == rtcw_pkg::A_STATUS)
			status_nxt = status_r & ~bus.wdata[rtcw_pkg::ST_W-1:0];
		// set beats clear
		status_nxt = status_nxt | evt;
		if (bus.wr && bus.addr == rtcw_pkg::A_MASK)
			mask_nxt = bus.wdata[rtcw_pkg::ST_W-1:0];
		irq_nxt = |(status_nxt & mask_nxt);
		rdata_nxt = 32'h00000000;
		if (bus.rd)
		begin
			unique case (bus.addr)
				rtcw_pkg::A_DATE: rdata_nxt = {4'h0, cal_t_r.year, 4'h0, cal_t_r.month, 3'h0, cal_t_r.day};
				rtcw_pkg::A_TIME: rdata_nxt = {5'h00, cal_t_r.wday, 3'h0, cal_t_r.hour, 2'h0, cal_t_r.min,
					2'h0, cal_t_r.sec};
				rtcw_pkg::A_SUBSEC: rdata_nxt = {24'h000000, subsec_r};
				rtcw_pkg::A_WAKE: rdata_nxt = {16'h0000, wake_to_r};
				rtcw_pkg::A_CAL: rdata_nxt = 32'(cal_r);
				rtcw_pkg::A_INFO: rdata_nxt = {14'h0000, ext_seen_r, por_seen_r, startup_r};
				rtcw_pkg::A_STATUS: rdata_nxt = {30'h00000000, status_r};
				rtcw_pkg::A_MASK: rdata_nxt = {30'h00000000, mask_r};
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			status_r <= '0;
			mask_r <= rtcw_pkg::RST_MASK;
			irq <= 1'b0;
			rdata <= 32'h00000000;
		end
		else
		begin
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			irq <= irq_nxt;
			rdata <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	subsec_load_a: assert property ((wr && (addr == rtcw_pkg::A_DATE || addr == rtcw_pkg::A_TIME)) |=> subsec_r == 8'hFF)
		else $error("subsecond not reloaded after a calendar write");
	subsec_down_a: assert property ((step_r && subsec_r != 8'h00 && !wr) |=> subsec_r == $past(subsec_r) - 8'h01)
		else $error("subsecond did not count down");
	sec_carry_a: assert property ((step_r && subsec_r == 8'h00 && cal_t_r.sec != 6'd59 && !wr)
		|=> cal_t_r.sec == $past(cal_t_r.sec) + 6'd1 && subsec_r == 8'hFF)
		else $error("second did not advance on subsecond wrap");
	wday_range_a: assert property ((step_r && subsec_r == 8'h00 && cal_t_r.wday == 3'd7 && cal_t_r.hour == 5'd23
		&& cal_t_r.min == 6'd59 && cal_t_r.sec == 6'd59 && !wr) |=> cal_t_r.wday == 3'd1)
		else $error("weekday did not wrap from Sunday to Monday");
	feb_roll_a: assert property ((step_r && subsec_r == 8'h00 && cal_t_r.month == 4'h2 && cal_t_r.day == 5'd28 && !leap
		&& cal_t_r.hour == 5'd23 && cal_t_r.min == 6'd59 && cal_t_r.sec == 6'd59 && !wr)
		|=> cal_t_r.day == 5'd1 && cal_t_r.month == 4'h3)
		else $error("February did not roll over in a common year");
	wake_off_a: assert property ((wake_to_r == 16'h0000) [*2] |-> !wake_pulse)
		else $error("wakeup fired while disabled");
	wake_sets_a: assert property (wake_pulse |=> status_r[rtcw_pkg::ST_WAKE_BIT])
		else $error("wakeup event not recorded");
	wake_gap_a: assert property ($rose(wake_pulse) && wake_to_r > 16'h0001 |=> !wake_pulse [*8])
		else $error("wakeup fired early");
	cal_range_a: assert property (cal_r >= rtcw_pkg::CAL_MIN && cal_r <= rtcw_pkg::CAL_MAX)
		else $error("calibration out of range");
	cal_read_a: assert property ((rd && addr == rtcw_pkg::A_CAL) |=> rdata == 32'($past(cal_r)))
		else $error("calibration read does not match value in effect");
	irq_mask_a: assert property (irq == |(status_r & mask_r))
		else $error("interrupt does not follow status and mask");
	por_info_a: assert property ((rd && addr == rtcw_pkg::A_INFO && por_seen_r) |=> rdata[16])
		else $error("power-on flag missing from info");
	step_gap_a: assert property (step_r |=> !step_r [*8])
		else $error("subsecond steps too close");

	sec_wrap_c: cover property (step_r && subsec_r == 8'h00);
	wake_fire_c: cover property (wake_pulse ##1 irq);
	cal_neg_c: cover property (cal_r < 11'sd0 && step_r);
	set_clear_c: cover property (wr && addr == rtcw_pkg::A_STATUS && |evt);
endmodule // rtcw_top

/* File: rtcw_top_tb.sv */
// rtcw_top_tb: self-checking bench for the calendar clock with wakeup timer
// assumes rtcw_pkg compiled first; the design carries its own assertions
`timescale 1ns/1ns
module rtcw_top_tb;
	localparam int MS_TB = 10;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} rtcw_row_t;
	logic clk;
	logic rst;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic por_flag;
	logic ext_rst_flag;
	logic osc_ready;
	logic irq;
	logic wake_pulse;
	int miscompares;
	int n_tests;
	int cyc = 0;
	int w;
	int t_rel;
	int t_osc;
	int t1;
	int t2;
	int n_pulse;
	int exp_ms;
	logic [31:0] d;
	rtcw_row_t rows [16];

	rtcw_top #(
		.MS_CYCLES(MS_TB),
		.TB_STEP(rtcw_pkg::TB_WRAP)
	) rtcw_top_i (
		.clk(clk),
		.rst(rst),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.por_flag(por_flag),
		.ext_rst_flag(ext_rst_flag),
		.osc_ready(osc_ready),
		.irq(irq),
		.wake_pulse(wake_pulse)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
		cyc <= cyc + 1;

	////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// rdata is sampled in its single valid cycle, then must drop to zero
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
		@(posedge clk);
		#1;
		check("rdata idle", rdata, 32'h00000000);
	endtask

	task automatic wait_pulse(output int t);
		int i;
		for (i = 0; i < 20 * MS_TB; i++)
		begin
			@(posedge clk);
			#1;
			if (wake_pulse === 1'b1)
				break;
		end
		t = cyc;
		if (i == 20 * MS_TB)
		begin
			miscompares++;
			$display("CHECK FAILED wake_pulse expected 1 seen timeout");
			give_verdict();
		end
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_rel = cyc;
		@(posedge clk);
		#1;
		check("irq in reset", {31'h0, irq}, 32'h00000000);
		check("wake in reset", {31'h0, wake_pulse}, 32'h00000000);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		miscompares = 0;
		n_tests = 0;
		rst = 1'b1;
		addr = 8'h00;
		wdata = 32'h00000000;
		wr = 1'b0;
		rd = 1'b0;
		por_flag = 1'b1;
		ext_rst_flag = 1'b0;
		osc_ready = 1'b0;
		// reset values first, then writes with readback
		rows[0] = {1'b0, rtcw_pkg::A_DATE, 32'h0, 32'h07D00101};
		rows[1] = {1'b0, rtcw_pkg::A_TIME, 32'h0, 32'h06000000};
		rows[2] = {1'b0, rtcw_pkg::A_SUBSEC, 32'h0, 32'h000000FF};
		rows[3] = {1'b0, rtcw_pkg::A_WAKE, 32'h0, 32'h00000000};
		rows[4] = {1'b0, rtcw_pkg::A_CAL, 32'h0, 32'h00000000};
		rows[5] = {1'b0, rtcw_pkg::A_MASK, 32'h0, 32'h00000000};
		rows[6] = {1'b0, 8'h20, 32'h0, 32'h00000000};
		rows[7] = {1'b1, rtcw_pkg::A_DATE, 32'h07E8021D, 32'h07E8021D};
		rows[8] = {1'b1, rtcw_pkg::A_TIME, 32'h07173B3B, 32'h07173B3B};
		rows[9] = {1'b0, rtcw_pkg::A_SUBSEC, 32'h0, 32'h000000FF};
		rows[10] = {1'b1, rtcw_pkg::A_TIME, 32'h010D0507, 32'h010D0507};
		rows[11] = {1'b1, rtcw_pkg::A_CAL, 32'h00000200, 32'h00000200};
		rows[12] = {1'b1, rtcw_pkg::A_CAL, 32'h00000258, 32'h00000200};
		rows[13] = {1'b1, rtcw_pkg::A_CAL, 32'hFFFFFE01, 32'hFFFFFE01};
		rows[14] = {1'b1, rtcw_pkg::A_CAL, 32'hFFFFFC18, 32'hFFFFFE01};
		rows[15] = {1'b1, 8'h24, 32'hFFFFFFFF, 32'h00000000};
		do_reset();
		foreach (rows[k])
		begin
			if (rows[k].wr)
				bus_wr(rows[k].addr, rows[k].wdata);
			bus_rd(rows[k].addr, d);
			check($sformatf("row %0d addr %h", k, rows[k].addr), d, rows[k].exp);
		end
		// read-only info ignores writes; startup time counts to oscillator start
		bus_wr(rtcw_pkg::A_INFO, 32'h00000000);
		osc_ready <= 1'b1;
		t_osc = cyc;
		repeat (20) @(posedge clk);
		bus_rd(rtcw_pkg::A_INFO, d);
		exp_ms = (t_osc - t_rel) / MS_TB;
		check("info por", {30'h0, d[17:16]}, 32'h00000001);
		check("info ms", {31'h0, (int'(d[15:0]) >= exp_ms - 1 && int'(d[15:0]) <= exp_ms + 1)}, 32'h1);
		// wakeup: period, pulse width, status, mask, clear
		bus_wr(rtcw_pkg::A_MASK, 32'h00000001);
		bus_wr(rtcw_pkg::A_WAKE, 32'h00000003);
		wait_pulse(t1);
		@(posedge clk);
		#1;
		check("wake width", {31'h0, wake_pulse}, 32'h00000000);
		@(posedge clk);
		#1;
		check("irq set", {31'h0, irq}, 32'h00000001);
		wait_pulse(t2);
		check("wake period", t2 - t1, 3 * MS_TB);
		bus_rd(rtcw_pkg::A_STATUS, d);
		check("status wake", d & 32'h1, 32'h00000001);
		bus_wr(rtcw_pkg::A_STATUS, 32'h00000001);
		bus_rd(rtcw_pkg::A_STATUS, d);
		check("status clear", d & 32'h1, 32'h00000000);
		check("irq clear", {31'h0, irq}, 32'h00000000);
		bus_wr(rtcw_pkg::A_MASK, 32'h00000000);
		wait_pulse(t1);
		repeat (3) @(posedge clk);
		#1;
		check("irq masked", {31'h0, irq}, 32'h00000000);
		bus_rd(rtcw_pkg::A_STATUS, d);
		check("status masked", d & 32'h1, 32'h00000001);
		// timeout zero stops further firings
		bus_wr(rtcw_pkg::A_WAKE, 32'h00000000);
		n_pulse = 0;
		repeat (10 * MS_TB)
		begin
			@(posedge clk);
			#1;
			if (wake_pulse !== 1'b0)
				n_pulse++;
		end
		check("wake off", n_pulse, 0);
		// rollover from Sunday 28 Feb 2023 23:59:59 on the one-tick-per-clock timebase
		bus_wr(rtcw_pkg::A_DATE, 32'h07E7021C);
		bus_wr(rtcw_pkg::A_TIME, 32'h07173B3B);
		bus_wr(rtcw_pkg::A_MASK, 32'h00000002);
		repeat (200) @(posedge clk);
		bus_rd(rtcw_pkg::A_SUBSEC, d);
		check("subsec down", {31'h0, (d == 32'h000000FE || d == 32'h000000FD)}, 32'h00000001);
		for (w = 0; w < 40000 && irq !== 1'b1; w++)
		begin
			@(posedge clk);
			#1;
		end
		check("second irq", {31'h0, irq}, 32'h00000001);
		if (irq !== 1'b1)
			give_verdict();
		bus_rd(rtcw_pkg::A_DATE, d);
		check("date roll", d, 32'h07E70301);
		bus_rd(rtcw_pkg::A_TIME, d);
		check("time roll", d, 32'h01000000);
		// second reset, now from the external source
		@(posedge clk);
		por_flag <= 1'b0;
		ext_rst_flag <= 1'b1;
		do_reset();
		repeat (20) @(posedge clk);
		bus_rd(rtcw_pkg::A_INFO, d);
		check("info ext", {30'h0, d[17:16]}, 32'h00000002);
		bus_rd(rtcw_pkg::A_DATE, d);
		check("date again", d, 32'h07D00101);
		bus_rd(rtcw_pkg::A_CAL, d);
		check("cal again", d, 32'h00000000);
		give_verdict();
	end
endmodule // rtcw_top_tb
